// ### hw/window_alert_capture.sv
// Top level: two-channel window comparator, alert and capture buffer.
`timescale 1ns/1ps
// Summary of operation
// - A channel's low side sets when the result is at or below its low limit.
// - A channel's high side sets when the result is at or above its high limit.
// - A full-scale high limit trips the high side only on full scale.
// - A zero low limit trips the low side only on zero.
// - Both sides are checked per conversion and either counts toward the alert.
// - The alert waits for a programmed run of conversions with a side set.
// - The alert rises on the sample that completes the programmed run outside the window.
// - Pre-alert mode stores every sample and stops at the alert.
// - A pre-alert stop leaves the 15 samples before plus the alerting one.
// - Post-alert mode stores from the alerting sample until 16 are held.
// - The host can read the 16 stored samples back after an alert.
// - Each limit is a low byte plus an upper nibble whose upper bits are ignored.
// - Each channel has one six-bit hysteresis used by both of its sides.
module window_alert_capture
    import window_alert_pkg::*;
(
    // Clock and reset
    input  wire logic                  clock,
    input  wire logic                  sys_rst,
    // Conversion result stream
    input  wire logic                  sample_valid,
    output logic                       sample_ready,
    input  wire logic [SAMPLE_W-1:0]   sample_data,
    input  wire logic                  sample_channel,
    // Channel zero limits and hysteresis
    input  wire logic [BYTE_W-1:0]     ch0_high_limit_low_byte,
    input  wire logic [BYTE_W-1:0]     ch0_high_limit_upper_nibble,
    input  wire logic [BYTE_W-1:0]     ch0_low_limit_low_byte,
    input  wire logic [BYTE_W-1:0]     ch0_low_limit_upper_nibble,
    input  wire logic [BYTE_W-1:0]     ch0_hysteresis,
    // Channel one limits and hysteresis
    input  wire logic [BYTE_W-1:0]     ch1_high_limit_low_byte,
    input  wire logic [BYTE_W-1:0]     ch1_high_limit_upper_nibble,
    input  wire logic [BYTE_W-1:0]     ch1_low_limit_low_byte,
    input  wire logic [BYTE_W-1:0]     ch1_low_limit_upper_nibble,
    input  wire logic [BYTE_W-1:0]     ch1_hysteresis,
    // Mode control
    input  wire logic                  monitor_enable,
    input  wire logic                  post_alert_mode,
    input  wire logic [EVENT_W-1:0]    event_count_target,
    input  wire logic                  rearm,
    // Alert toward the host
    output logic                       alert,
    output logic                       alert_channel,
    output logic                       alert_high_side,
    // Comparator state
    output logic [1:0]                 high_side_flag,
    output logic [1:0]                 low_side_flag,
    // Capture status and readback
    output logic                       capture_done,
    output logic [CAPTURE_AW:0]        capture_fill,
    input  wire logic [CAPTURE_AW-1:0] buffer_read_index,
    output logic [SAMPLE_W-1:0]        buffer_read_data,
    output logic                       buffer_read_channel
);

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    // Sequencer.
    capture_state_t              state;
    capture_state_t              next_state;

    logic [FIFO_WORD_W-1:0]      fifo_word;
    logic                        fifo_valid;
    logic                        core_ready;
    logic                        take;
    logic [SAMPLE_W-1:0]         value;
    logic                        chan;
    logic [1:0]                  chan_valid;

    logic [1:0]                  trip;
    logic [1:0]                  trip_high;
    logic                        alerting;
    logic                        store;

    // Buffer.
    logic [SAMPLE_W-1:0]         buf_data [CAPTURE_N];
    logic                        buf_chan [CAPTURE_N];
    logic [CAPTURE_AW-1:0]       write_ptr;
    logic [CAPTURE_AW-1:0]       oldest_ptr;
    logic [CAPTURE_AW-1:0]       read_ptr;

    // Limits.
    logic [SAMPLE_W-1:0]         ch0_high;
    logic [SAMPLE_W-1:0]         ch0_low;
    logic [SAMPLE_W-1:0]         ch1_high;
    logic [SAMPLE_W-1:0]         ch1_low;

    // ------------------------------------------------------------------
    // Limit assembly
    // ------------------------------------------------------------------
    // Bits above the nibble and above the six hysteresis bits are
    // reserved and ignored.
    assign ch0_high = join_limit(ch0_high_limit_upper_nibble[3:0],
        ch0_high_limit_low_byte);
    assign ch0_low  = join_limit(ch0_low_limit_upper_nibble[3:0],
        ch0_low_limit_low_byte);
    assign ch1_high = join_limit(ch1_high_limit_upper_nibble[3:0],
        ch1_high_limit_low_byte);
    assign ch1_low  = join_limit(ch1_low_limit_upper_nibble[3:0],
        ch1_low_limit_low_byte);

    // ------------------------------------------------------------------
    // Input buffering
    // ------------------------------------------------------------------
    // The FIFO absorbs conversions while the core is held;
    // when it is full the converter waits.
    sample_fifo #(
        .WIDTH (FIFO_WORD_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clock     (clock),
        .sys_rst   (sys_rst),
        .in_valid  (sample_valid),
        .in_ready  (sample_ready),
        .in_data   ({sample_channel, sample_data}),
        .out_valid (fifo_valid),
        .out_ready (core_ready),
        .out_data  (fifo_word)
    );

    // The core stalls in idle and hold, so queued
    // conversions never overwrite a held capture.
    assign core_ready = (state == CAP_ARMED) || (state == CAP_FILLING);
    assign take       = fifo_valid && core_ready;
    assign value      = fifo_word[SAMPLE_W-1:0];
    assign chan       = fifo_word[SAMPLE_W];
    assign chan_valid = {take && chan, take && !chan};

    // ------------------------------------------------------------------
    // Comparator channels
    // ------------------------------------------------------------------
    // Channel zero comparator.
    window_channel u_channel_zero (
        .clock         (clock),
        .sys_rst       (sys_rst),
        .sample_valid  (chan_valid[0]),
        .sample_value  (value),
        .counter_clear (rearm),
        .high_limit    (ch0_high),
        .low_limit     (ch0_low),
        .hysteresis    (ch0_hysteresis[HYS_W-1:0]),
        .event_target  (event_count_target),
        .high_flag     (high_side_flag[0]),
        .low_flag      (low_side_flag[0]),
        .trip          (trip[0]),
        .trip_high     (trip_high[0])
    );

    // Channel one comparator.
    window_channel u_channel_one (
        .clock         (clock),
        .sys_rst       (sys_rst),
        .sample_valid  (chan_valid[1]),
        .sample_value  (value),
        .counter_clear (rearm),
        .high_limit    (ch1_high),
        .low_limit     (ch1_low),
        .hysteresis    (ch1_hysteresis[HYS_W-1:0]),
        .event_target  (event_count_target),
        .high_flag     (high_side_flag[1]),
        .low_flag      (low_side_flag[1]),
        .trip          (trip[1]),
        .trip_high     (trip_high[1])
    );

    // Only the first trip while armed is the alerting sample.
    assign alerting = (state == CAP_ARMED) && (trip != 2'b00);

    // ------------------------------------------------------------------
    // Capture sequencer
    // ------------------------------------------------------------------
    always_comb begin
        next_state = state;
        store      = 1'b0;

        case (state)
            CAP_IDLE: begin
                if (monitor_enable) begin
                    next_state = CAP_ARMED;
                end
            end

            CAP_ARMED: begin
                if (!monitor_enable) begin
                    next_state = CAP_IDLE;
                end else if (alerting) begin
                    store      = take;
                    next_state = post_alert_mode ? CAP_FILLING : CAP_HELD;
                end else begin
                    store = take && !post_alert_mode;
                end
            end

            CAP_FILLING: begin
                store = take;
                if (take && write_ptr == PTR_LAST) begin
                    next_state = CAP_HELD;
                end
            end

            CAP_HELD: begin
                if (rearm) begin
                    next_state = monitor_enable ? CAP_ARMED : CAP_IDLE;
                end
            end
            default: begin
                next_state = CAP_IDLE;
            end
        endcase
    end

    // State register.
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            state <= CAP_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Write pointer: free-running before the alert in pre-alert mode, held in
    // post-alert mode until the alerting sample restarts it.
    always_ff @(posedge clock) begin
        if (sys_rst || rearm) begin
            write_ptr <= PTR_RESET;
        end else if (alerting && post_alert_mode && take) begin
            write_ptr <= PTR_RESET + 4'h1;
        end else if (store) begin
            write_ptr <= write_ptr + 4'h1;
        end
    end

    // Sample storage.
    always_ff @(posedge clock) begin
        if (store) begin
            if (alerting && post_alert_mode) begin
                buf_data[PTR_RESET] <= value;
                buf_chan[PTR_RESET] <= chan;
            end else begin
                buf_data[write_ptr] <= value;
                buf_chan[write_ptr] <= chan;
            end
        end
    end

    // Count of valid entries, up to the buffer size.
    always_ff @(posedge clock) begin
        if (sys_rst || rearm) begin
            capture_fill <= FILL_RESET;
        end else if (alerting && post_alert_mode && take) begin
            capture_fill <= FILL_RESET + 5'h01;
        end else if (store && capture_fill != FILL_FULL) begin
            capture_fill <= capture_fill + 5'h01;
        end
    end

    // ------------------------------------------------------------------
    // Alert
    // ------------------------------------------------------------------
    // The alert is sticky until rearm, which also wins over an alert in its own cycle.
    always_ff @(posedge clock) begin
        if (sys_rst || rearm) begin
            alert           <= 1'b0;
            alert_channel   <= 1'b0;
            alert_high_side <= 1'b0;
        end else if (alerting) begin
            alert           <= 1'b1;
            alert_channel   <= trip[1] && !trip[0];
            alert_high_side <= trip[0] ? trip_high[0] : trip_high[1];
        end
    end

    // Done while a capture is held.
    assign capture_done = (state == CAP_HELD);

    // ------------------------------------------------------------------
    // Host readback
    // ------------------------------------------------------------------
    // Index zero is the oldest sample: the slot after the last
    // write, or slot zero in post-alert mode.
    assign oldest_ptr = post_alert_mode ? PTR_RESET : write_ptr;
    assign read_ptr   = oldest_ptr + buffer_read_index;

    // Registered read port, one cycle behind the index.
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            buffer_read_data    <= SAMPLE_RESET;
            buffer_read_channel <= 1'b0;
        end else begin
            buffer_read_data    <= buf_data[read_ptr];
            buffer_read_channel <= buf_chan[read_ptr];
        end
    end

endmodule : window_alert_capture

// ### hw/window_alert_pkg.sv
// Shared constants, types and functions of the alert block.
package window_alert_pkg;

    // ------------------------------------------------------------------
    // Widths and depths
    // ------------------------------------------------------------------
    localparam int SAMPLE_W     = 12;
    localparam int BYTE_W       = 8;
    localparam int NIBBLE_W     = 4;
    localparam int HYS_W        = 6;
    localparam int EVENT_W      = 8;
    localparam int CAPTURE_N    = 16;
    localparam int CAPTURE_AW   = 4;
    localparam int FIFO_DEPTH   = 32;
    localparam int FIFO_WORD_W  = SAMPLE_W + 1;

    // ------------------------------------------------------------------
    // Codes and reset values
    // ------------------------------------------------------------------
    localparam logic [SAMPLE_W-1:0]   FULL_SCALE     = 12'hFFF;
    localparam logic [SAMPLE_W-1:0]   ZERO_SCALE     = 12'h000;
    localparam logic [SAMPLE_W-1:0]   SAMPLE_RESET   = 12'h000;
    localparam logic [EVENT_W-1:0]    COUNT_RESET    = 8'h00;
    localparam logic [EVENT_W-1:0]    COUNT_MAX      = 8'hFF;
    localparam logic [CAPTURE_AW-1:0] PTR_RESET      = 4'h0;
    localparam logic [CAPTURE_AW-1:0] PTR_LAST       = 4'hF;
    localparam logic [CAPTURE_AW:0]   FILL_RESET     = 5'h00;
    localparam logic [CAPTURE_AW:0]   FILL_FULL      = 5'h10;

    // ------------------------------------------------------------------
    // Capture sequencer states
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        CAP_IDLE    = 2'b00,
        CAP_ARMED   = 2'b01,
        CAP_FILLING = 2'b10,
        CAP_HELD    = 2'b11
    } capture_state_t;

    // Joins an upper nibble and a low byte into one 12-bit limit.
    function automatic logic [SAMPLE_W-1:0] join_limit(input logic [NIBBLE_W-1:0] upper,
                                                      input logic [BYTE_W-1:0]   lower);
        join_limit = {upper, lower};
    endfunction : join_limit

    // Unsigned subtraction that stops at zero.
    function automatic logic [SAMPLE_W-1:0] sat_sub(input logic [SAMPLE_W-1:0] a,
                                                   input logic [HYS_W-1:0]    b);
        sat_sub = (a > {6'h00, b}) ? a - {6'h00, b} : ZERO_SCALE;
    endfunction : sat_sub

    // Unsigned addition that stops at full scale.
    function automatic logic [SAMPLE_W-1:0] sat_add(input logic [SAMPLE_W-1:0] a,
                                                   input logic [HYS_W-1:0]    b);
        logic [SAMPLE_W:0] sum;
        sum     = {1'b0, a} + {7'h00, b};
        sat_add = sum[SAMPLE_W] ? FULL_SCALE : sum[SAMPLE_W-1:0];
    endfunction : sat_add

endpackage : window_alert_pkg

// ### hw/sample_fifo.sv
// Synchronous FIFO with valid/ready on both sides.
`timescale 1ns/1ps
module sample_fifo
    import window_alert_pkg::*;
#(
    parameter int WIDTH = FIFO_WORD_W,
    parameter int DEPTH = FIFO_DEPTH
) (
    // Clock and reset
    input  wire logic             clock,
    input  wire logic             sys_rst,
    // Filling side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Draining side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);

    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wr_ptr;
    logic [AW:0]      rd_ptr;
    logic             push;
    logic             pop;
    logic             full;
    logic             empty;

    // ------------------------------------------------------------------
    // Flags
    // ------------------------------------------------------------------
    // The extra pointer bit separates full from empty without a counter.
    assign empty     = (wr_ptr == rd_ptr);
    assign full      = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
    assign in_ready  = !full;
    assign out_valid = !empty;
    assign push      = in_valid && !full;
    assign pop       = out_ready && !empty;
    assign out_data  = mem[rd_ptr[AW-1:0]];

    // Storage write.
    always_ff @(posedge clock) begin
        if (push) begin
            mem[wr_ptr[AW-1:0]] <= in_data;
        end
    end

    // Pointer update.
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
        end
    end

endmodule : sample_fifo

// ### hw/window_channel.sv
// One comparator channel with its event counter.
`timescale 1ns/1ps
module window_channel
    import window_alert_pkg::*;
(
    // Clock and reset
    input  wire logic                clock,
    input  wire logic                sys_rst,
    // Conversion for this channel
    input  wire logic                sample_valid,
    input  wire logic [SAMPLE_W-1:0] sample_value,
    input  wire logic                counter_clear,
    // Settings
    input  wire logic [SAMPLE_W-1:0] high_limit,
    input  wire logic [SAMPLE_W-1:0] low_limit,
    input  wire logic [HYS_W-1:0]    hysteresis,
    input  wire logic [EVENT_W-1:0]  event_target,
    // Results
    output logic                     high_flag,
    output logic                     low_flag,
    output logic                     trip,
    output logic                     trip_high
);

    logic                next_high;
    logic                next_low;
    logic [EVENT_W-1:0]  event_count;
    logic [EVENT_W-1:0]  next_count;
    logic [EVENT_W-1:0]  target;

    // ------------------------------------------------------------------
    // Comparison
    // ------------------------------------------------------------------
    // A set side releases only once the value moves back past the hysteresis.
    always_comb begin
        if (high_flag) begin
            next_high = (sample_value >= sat_sub(high_limit, hysteresis));
        end else begin
            next_high = (sample_value >= high_limit);
        end
        if (low_flag) begin
            next_low = (sample_value <= sat_add(low_limit, hysteresis));
        end else begin
            next_low = (sample_value <= low_limit);
        end
    end

    // A count of zero acts as one.
    assign target = (event_target == COUNT_RESET) ? 8'h01 : event_target;

    // Either side extends the run.
    always_comb begin
        if (next_high || next_low) begin
            next_count = (event_count == COUNT_MAX) ? COUNT_MAX : event_count + 8'h01;
        end else begin
            next_count = COUNT_RESET;
        end
    end

    // Trip as the run completes; at a target of 255 the saturated count trips again on each later sample.
    assign trip      = sample_valid && (next_count == target);
    assign trip_high = next_high;

    // Comparator outputs hold between conversions.
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            high_flag <= 1'b0;
            low_flag  <= 1'b0;
        end else if (sample_valid) begin
            high_flag <= next_high;
            low_flag  <= next_low;
        end
    end

    // Consecutive-conversion counter.
    always_ff @(posedge clock) begin
        if (sys_rst || counter_clear) begin
            event_count <= COUNT_RESET;
        end else if (sample_valid) begin
            event_count <= next_count;
        end
    end

endmodule : window_channel

// ### tb/window_alert_capture_sva.sv
// Port-level checker for the alert capture block.
`timescale 1ns/1ps
module window_alert_capture_chk
    import window_alert_pkg::*;
(
    // Clock and reset
    input wire logic                clock,
    input wire logic                sys_rst,
    // Observed ports
    input wire logic                rearm,
    input wire logic                monitor_enable,
    input wire logic                post_alert_mode,
    input wire logic                sample_ready,
    input wire logic                alert,
    input wire logic                alert_channel,
    input wire logic                capture_done,
    input wire logic [CAPTURE_AW:0] capture_fill
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    // The alert is a level for the host, so it must not drop by itself.
    alert_sticky_a: assert property (alert && !rearm |=> alert)
        else $error("alert dropped without rearm");
    rearm_clears_a: assert property (rearm |=> !alert)
        else $error("alert survived rearm");
    fill_range_a: assert property (capture_fill <= FILL_FULL)
        else $error("fill above depth");
    fill_grows_a: assert property (!rearm && monitor_enable |=> capture_fill >= $past(capture_fill))
        else $error("fill count shrank");
    post_full_a: assert property (capture_done && post_alert_mode |-> capture_fill == FILL_FULL)
        else $error("post capture short");
    pre_stop_a: assert property ($rose(alert) && !post_alert_mode |-> ##[0:2] capture_done)
        else $error("pre capture not held");
    post_open_a: assert property ($rose(alert) && post_alert_mode |-> !capture_done)
        else $error("post capture closed at alert");
    channel_hold_a: assert property (alert && !rearm |=> $stable(alert_channel))
        else $error("alert channel moved");

    // Main scenarios.
    pre_seen_c: cover property ($rose(alert) && !post_alert_mode);
    post_seen_c: cover property ($rose(capture_done) && post_alert_mode);
    full_seen_c: cover property (!sample_ready);
endmodule : window_alert_capture_chk

bind window_alert_capture window_alert_capture_chk chk_u (.*);

// ### tb/host_model.sv
// Host model that reads the capture buffer back.
`timescale 1ns/1ps
module host_model
    import window_alert_pkg::*;
(
    // Clock and request
    input wire logic              clock,
    input wire logic              fetch,
    // Readback port
    input wire logic [SAMPLE_W-1:0] buffer_read_data,
    output logic [CAPTURE_AW-1:0] buffer_read_index,
    // Collected samples
    output logic [SAMPLE_W-1:0]   got [CAPTURE_N],
    output logic                  busy
);
    logic [CAPTURE_AW:0] step = '0;

    // Walks the index once per cycle; data lags by one.
    initial busy = 1'b0;
    initial buffer_read_index = '0;
    always @(posedge clock) begin
        if (fetch) begin
            busy              <= 1'b1;
            step              <= '0;
            buffer_read_index <= '0;
        end else if (busy) begin
            step              <= step + 5'h01;
            buffer_read_index <= CAPTURE_AW'(step + 5'h01);
            if (step != 5'h00) begin
                got[step - 5'h01] <= buffer_read_data;
            end
            if (step == FILL_FULL) begin
                busy <= 1'b0;
            end
        end
    end
endmodule : host_model

// ### tb/window_alert_capture_tb.sv
// Self-checking bench for the alert capture block.
`timescale 1ns/1ps
module window_alert_capture_tb
    import window_alert_pkg::*;
;
    logic clock = 0, sys_rst = 1, sample_valid = 0, sample_channel = 0;
    logic monitor_enable = 0, post_alert_mode = 0, rearm = 0, fetch = 0;
    logic [SAMPLE_W-1:0] sample_data = '0;
    logic [BYTE_W-1:0] lim [10] = '{default: 8'h00};
    logic [EVENT_W-1:0] event_count_target = 8'h00;
    logic sample_ready, alert, alert_channel, alert_high_side, capture_done, host_busy;
    logic [1:0] high_side_flag, low_side_flag;
    logic buffer_read_channel;
    logic [CAPTURE_AW:0] capture_fill;
    logic [CAPTURE_AW-1:0] buffer_read_index;
    logic [SAMPLE_W-1:0] buffer_read_data;
    logic [SAMPLE_W-1:0] got [CAPTURE_N];
    logic [SAMPLE_W-1:0] hist [$];
    int num_errors = 0, n_tests = 0;

    always #2.5 clock = ~clock;

    window_alert_capture dut_u (.clock, .sys_rst, .sample_valid, .sample_ready, .sample_data,
        .sample_channel, .ch0_high_limit_low_byte(lim[0]), .ch0_high_limit_upper_nibble(lim[1]),
        .ch0_low_limit_low_byte(lim[2]), .ch0_low_limit_upper_nibble(lim[3]),
        .ch0_hysteresis(lim[4]), .ch1_high_limit_low_byte(lim[5]),
        .ch1_high_limit_upper_nibble(lim[6]), .ch1_low_limit_low_byte(lim[7]),
        .ch1_low_limit_upper_nibble(lim[8]), .ch1_hysteresis(lim[9]), .monitor_enable,
        .post_alert_mode, .event_count_target, .rearm, .alert, .alert_channel, .alert_high_side,
        .high_side_flag, .low_side_flag, .capture_done, .capture_fill, .buffer_read_index,
        .buffer_read_data, .buffer_read_channel);
    host_model host_u (.clock, .fetch, .buffer_read_data, .buffer_read_index, .got,
        .busy(host_busy));

    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task automatic report_and_stop();
        $display("Comparisons %0d, mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : report_and_stop

    task automatic check(input logic [SAMPLE_W-1:0] seen, input logic [SAMPLE_W-1:0] exp);
        n_tests++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    // A wait that runs out fails the run.
    task automatic give_up();
        num_errors++;
        $display("ERROR at %0t: wait ran out", $time);
        report_and_stop();
    endtask : give_up

    // Holds the word until the FIFO takes it.
    task automatic push(input logic ch, input logic [SAMPLE_W-1:0] v);
        int n;
        n = 0;
        sample_valid   <= 1'b1;
        sample_channel <= ch;
        sample_data    <= v;
        @(posedge clock);
        while (sample_ready !== 1'b1) begin
            if (++n > 200) give_up();
            @(posedge clock);
        end
        hist.push_back(v);
    endtask : push

    task automatic await_capture();
        int n;
        n = 0;
        sample_valid <= 1'b0;
        @(posedge clock);
        while (capture_done !== 1'b1) begin
            if (++n > 200) give_up();
            @(posedge clock);
        end
    endtask : await_capture

    task automatic read_back(input logic [SAMPLE_W-1:0] exp [$]);
        int n;
        n = 0;
        fetch <= 1'b1;
        @(posedge clock);
        fetch <= 1'b0;
        repeat (2) @(posedge clock);
        while (host_busy !== 1'b0) begin
            if (++n > 40) give_up();
            @(posedge clock);
        end
        for (int k = 0; k < CAPTURE_N; k++) check(got[k], exp[k]);
    endtask : read_back

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        repeat (6) @(posedge clock);
        sys_rst <= 1'b0;
        // Pre-alert: high limit 0x800, low limit zero, run of three.
        lim[1] <= 8'h08;
        event_count_target <= 8'h03;
        push(1'b0, 12'h001);
        for (int i = 1; i < 32; i++) push(1'b0, SAMPLE_W'(32'h400 + i));
        sample_valid <= 1'b0;
        @(posedge clock);
        check(sample_ready, 1'b0);
        monitor_enable <= 1'b1;
        // A run of two broken by an in-window sample must not alert.
        push(1'b0, 12'h800);
        push(1'b0, 12'h800);
        push(1'b0, 12'h400);
        repeat (3) push(1'b0, 12'h800);
        await_capture();
        check(alert, 1'b1);
        check(alert_high_side, 1'b1);
        check(alert_channel, 1'b0);
        check(low_side_flag[0], 1'b0);
        check(high_side_flag[0], 1'b1);
        check(capture_fill, FILL_FULL);
        check(sample_ready, 1'b1);
        read_back(hist[$-15:$]);
        $display("Test pre-alert capture finished");
        // Post-alert on channel one: high at full scale, low limit 0x100.
        rearm <= 1'b1;
        @(posedge clock);
        rearm <= 1'b0;
        hist.delete();
        {post_alert_mode, event_count_target} <= {1'b1, 8'h00};
        {lim[5], lim[6], lim[7], lim[8], lim[9]} <= {8'hFF, 8'h0F, 8'h00, 8'h01, 8'h04};
        @(posedge clock);
        check(alert, 1'b0);
        push(1'b1, 12'hFFE);
        push(1'b1, 12'h100);
        for (int i = 0; i < 15; i++) push(1'b1, SAMPLE_W'(32'h200 + i));
        await_capture();
        check(alert_channel, 1'b1);
        check(alert_high_side, 1'b0);
        check(capture_fill, FILL_FULL);
        read_back(hist[1:16]);
        check(buffer_read_channel, 1'b1);
        $display("Test post-alert capture finished");
        report_and_stop();
    end
endmodule : window_alert_capture_tb
